// file: src/tdc_consts.vh
// How it works
// - Auto-config bit 0 means use decoded parameters; 1 turns it off.
// - With auto-config off, forced registers drive transform, guard, modulation, rates, hierarchy.
// - Transform size: 1011 2K, 1100 4K, 1101 8K (reset); others reserved.
// - Guard: 001 1/32 (reset), 010 1/16, 011 1/8, 100 1/4.
// - Modulation 03h..0Bh, reset QPSK; cable always forced, terrestrial only when auto off.
// - HP and LP code rates: 0001 1/2 reset, 0010, 0011, 0101, 0111.
// - Hierarchy: 001 none (reset), 010, 011, 101; others reserved.
// - Channel width 14 bits in 10 kHz units, reset 0320h.
// - Carrier span in kHz; zero selects 50 kHz.
// - Phase compensation enabled while bit is 1 (reset).
// - Symbol clock range in ppm, reset 64h, limited to 200.
// - Burst-noise suppression only while enable bit is 1; resets 0.
// - Quick-detect duration 4 bits, reset 0010, sets observation time.
// - Nonzero relock level N restarts acquisition when PER exceeds 2^-N; never in cable mode.
// - Measure once per second; block relock while BER below 2^-M.
// - Four loop gains, resets 1101, 1001, 1011, 0110.
// - Bit 0 boot-complete reads 0 while booting, 1 when done.
// - Bit 2 watchdog fault; writing 1 to self-clearing bit 1 clears it.
// - Fault-reset enable resets processor on error; active-low fault bit.
// - Patch header and target words, 32 bits, reset zero.
// - Boot entry pointer, 32-bit RW, reset zero, used as jump address.
`ifndef TDC_CONSTS_VH
`define TDC_CONSTS_VH
`define TDC_A_AUTO      12'h2_e8
`define TDC_A_FFT       12'h2_ec
`define TDC_A_GUARD     12'h2_f0
`define TDC_A_MOD       12'h2_f4
`define TDC_A_HP        12'h2_f8
`define TDC_A_LP        12'h3_00
`define TDC_A_HIER      12'h3_04
`define TDC_A_BW        12'h3_08
`define TDC_A_SPAN      12'h3_0c
`define TDC_A_CPE       12'h3_10
`define TDC_A_PPM       12'h3_18
`define TDC_A_BURST     12'h3_1c
`define TDC_A_QDET      12'h3_20
`define TDC_A_PER       12'h3_24
`define TDC_A_BER       12'h3_28
`define TDC_A_CGA       12'h3_34
`define TDC_A_CGF       12'h3_36
`define TDC_A_SGA       12'h3_38
`define TDC_A_SGF       12'h3_3a
`define TDC_A_BOOT      12'h3_41
`define TDC_A_PATCHREV  12'h3_44
`define TDC_A_JUMP      12'h3_48
`define TDC_A_FAULT     12'h3_5c
`define TDC_A_HDR       12'h3_64
`define TDC_A_TGT       12'h3_68
`define TDC_RST_FFT     4'hd
`define TDC_RST_GUARD   3'h1
`define TDC_RST_MOD     6'h03
`define TDC_RST_RATE    4'h1
`define TDC_RST_HIER    3'h1
`define TDC_RST_BW      14'h0320
`define TDC_RST_PPM     8'h64
`define TDC_MAX_PPM     8'hc8
`define TDC_DEF_SPAN    12'h032
`define TDC_RST_QDET    4'h2
`define TDC_RST_PER     5'h06
`define TDC_RST_BER     5'h08
`define TDC_RST_CGA     4'hd
`define TDC_RST_CGF     4'h9
`define TDC_RST_SGA     4'hb
`define TDC_RST_SGF     4'h6
`define TDC_FFT_2K      4'hb
`define TDC_FFT_8K      4'hd
`define TDC_GI_LO       3'h1
`define TDC_GI_HI       3'h4
`define TDC_MOD_QPSK    6'h03
`define TDC_MOD_Q16     6'h07
`define TDC_MOD_Q256    6'h0b
`define TDC_B_BOOT      0
`define TDC_B_WDCLR     1
`define TDC_B_WDERR     2
`define TDC_B_RSTEN     0
`define TDC_B_ERRN      1
`define TDC_MEAS_SEC    1
`define TDC_MEAS_CYC    (`TDC_MEAS_SEC * 250000000)
`endif

// file: src/tdc_config_regs.v
`timescale 1ns/10ps
`include "tdc_consts.vh"
module tdc_config_regs
#(
   parameter MEAS_CYCLES = `TDC_MEAS_CYC
)
(
   input  wire        clk_sys_i,
   input  wire        arst_n_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [11:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        cable_mode_i,
   input  wire [3:0]  dec_fft_i,
   input  wire [2:0]  dec_guard_i,
   input  wire [5:0]  dec_mod_i,
   input  wire [3:0]  dec_hp_i,
   input  wire [3:0]  dec_lp_i,
   input  wire [2:0]  dec_hier_i,
   input  wire [4:0]  per_level_i,
   input  wire [4:0]  ber_level_i,
   input  wire        boot_done_i,
   input  wire        wdog_err_i,
   input  wire        core_err_i,
   output reg  [31:0] reg_rdata_o,
   output reg  [3:0]  use_fft_o,
   output reg  [2:0]  use_guard_o,
   output reg  [5:0]  use_mod_o,
   output reg  [3:0]  use_hp_o,
   output reg  [3:0]  use_lp_o,
   output reg  [2:0]  use_hier_o,
   output reg  [13:0] chan_width_o,
   output reg  [11:0] carrier_span_o,
   output reg         phase_fix_en_o,
   output reg  [7:0]  osc_ppm_o,
   output reg         burst_sup_en_o,
   output reg  [3:0]  qdet_dur_o,
   output reg  [3:0]  cg_acq_o,
   output reg  [3:0]  cg_fol_o,
   output reg  [3:0]  sg_acq_o,
   output reg  [3:0]  sg_fol_o,
   output reg         relock_o,
   output reg  [31:0] boot_entry_o,
   output reg  [31:0] patch_hdr_o,
   output reg  [31:0] patch_tgt_o,
   output reg         core_reset_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers
reg        auto_off_r;
reg [3:0]  fft_r;
reg [2:0]  guard_r;
reg [5:0]  mod_r;
reg [3:0]  hp_r;
reg [3:0]  lp_r;
reg [2:0]  hier_r;
reg [13:0] bw_r;
reg [11:0] span_r;
reg        cpe_r;
reg [7:0]  ppm_r;
reg        burst_r;
reg [3:0]  qdet_r;
reg [4:0]  per_r;
reg [3:0]  cga_r;
reg [3:0]  cgf_r;
reg [3:0]  sga_r;
reg [3:0]  sgf_r;
reg [7:0]  prev_r;
reg [31:0] jump_r;
reg        rsten_r;
reg [31:0] hdr_r;
reg [31:0] tgt_r;
reg        wderr_r;
reg        halted_r;
reg [27:0] sec_cnt_r;
reg        tick_r;
reg        boot_s1_r;
reg        boot_s2_r;
reg        wd_s1_r;
reg        wd_s2_r;
reg        ce_s1_r;
reg        ce_s2_r;
reg        cab_s1_r;
reg        cab_s2_r;

// Bit 1 of the status byte is a pulse: it clears the flag and always reads back 0
wire wr_hit_wdclr = reg_wr_i && (reg_addr_i == `TDC_A_BOOT) && reg_wdata_i[`TDC_B_WDCLR];

////////////////////////////////////////////////////////////////////////////////
// Pin inputs from the processor and front end cross in via two flops
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
   begin
      boot_s1_r <= 1'b0;
      boot_s2_r <= 1'b0;
      wd_s1_r   <= 1'b0;
      wd_s2_r   <= 1'b0;
      ce_s1_r   <= 1'b0;
      ce_s2_r   <= 1'b0;
      cab_s1_r  <= 1'b0;
      cab_s2_r  <= 1'b0;
   end
   else
   begin
      boot_s1_r <= boot_done_i;
      boot_s2_r <= boot_s1_r;
      wd_s1_r   <= wdog_err_i;
      wd_s2_r   <= wd_s1_r;
      ce_s1_r   <= core_err_i;
      ce_s2_r   <= ce_s1_r;
      cab_s1_r  <= cable_mode_i;
      cab_s2_r  <= cab_s1_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes
// Reserved codes are stored as written; the consumer decides what they mean
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
   begin
      auto_off_r <= 1'b0;
      fft_r      <= `TDC_RST_FFT;
      guard_r    <= `TDC_RST_GUARD;
      mod_r      <= `TDC_RST_MOD;
      hp_r       <= `TDC_RST_RATE;
      lp_r       <= `TDC_RST_RATE;
      hier_r     <= `TDC_RST_HIER;
      bw_r       <= `TDC_RST_BW;
      span_r     <= 12'h000;
      cpe_r      <= 1'b1;
      ppm_r      <= `TDC_RST_PPM;
      burst_r    <= 1'b0;
      qdet_r     <= `TDC_RST_QDET;
      per_r      <= `TDC_RST_PER;
      cga_r      <= `TDC_RST_CGA;
      cgf_r      <= `TDC_RST_CGF;
      sga_r      <= `TDC_RST_SGA;
      sgf_r      <= `TDC_RST_SGF;
      prev_r     <= 8'h00;
      jump_r     <= 32'h0000_0000;
      rsten_r    <= 1'b1;
      hdr_r      <= 32'h0000_0000;
      tgt_r      <= 32'h0000_0000;
   end
   else if (reg_wr_i)
   begin
      if (reg_addr_i == `TDC_A_AUTO)
         auto_off_r <= reg_wdata_i[0];
      else if (reg_addr_i == `TDC_A_FFT)
         fft_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_GUARD)
         guard_r <= reg_wdata_i[2:0];
      else if (reg_addr_i == `TDC_A_MOD)
         mod_r <= reg_wdata_i[5:0];
      else if (reg_addr_i == `TDC_A_HP)
         hp_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_LP)
         lp_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_HIER)
         hier_r <= reg_wdata_i[2:0];
      else if (reg_addr_i == `TDC_A_BW)
         bw_r <= reg_wdata_i[13:0];
      else if (reg_addr_i == `TDC_A_SPAN)
         span_r <= reg_wdata_i[11:0];
      else if (reg_addr_i == `TDC_A_CPE)
         cpe_r <= reg_wdata_i[0];
      else if (reg_addr_i == `TDC_A_PPM)
         ppm_r <= reg_wdata_i[7:0];
      else if (reg_addr_i == `TDC_A_BURST)
         burst_r <= reg_wdata_i[0];
      else if (reg_addr_i == `TDC_A_QDET)
         qdet_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_PER)
         per_r <= reg_wdata_i[4:0];
      else if (reg_addr_i == `TDC_A_CGA)
         cga_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_CGF)
         cgf_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_SGA)
         sga_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_SGF)
         sgf_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == `TDC_A_PATCHREV)
         prev_r <= reg_wdata_i[7:0];
      else if (reg_addr_i == `TDC_A_JUMP)
         jump_r <= reg_wdata_i;
      else if (reg_addr_i == `TDC_A_FAULT)
         rsten_r <= reg_wdata_i[`TDC_B_RSTEN];
      else if (reg_addr_i == `TDC_A_HDR)
         hdr_r <= reg_wdata_i;
      else if (reg_addr_i == `TDC_A_TGT)
         tgt_r <= reg_wdata_i;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Watchdog and processor fault state
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
   begin
      wderr_r  <= 1'b0;
      halted_r <= 1'b0;
   end
   else
   begin
      // A new watchdog error in the clearing cycle wins over the clear
      if (wd_s2_r)
         wderr_r <= 1'b1;
      else if (wr_hit_wdclr)
         wderr_r <= 1'b0;
      // Halted only when reset-on-error is off; otherwise the core restarts
      halted_r <= ce_s2_r && !rsten_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// One-second measurement tick and relock decision
// Sized for a full second at 250 MHz; simulation shortens it through the parameter
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
   begin
      sec_cnt_r <= 28'h000_0000;
      tick_r    <= 1'b0;
   end
   else if (sec_cnt_r == MEAS_CYCLES - 1)
   begin
      sec_cnt_r <= 28'h000_0000;
      tick_r    <= 1'b1;
   end
   else
   begin
      sec_cnt_r <= sec_cnt_r + 28'h000_0001;
      tick_r    <= 1'b0;
   end
end

// Levels are exponents: PER above 2^-N means measured level below N.
// BER below 2^-M means measured level above M, which holds the lock.
wire per_bad  = (per_r != 5'h00) && (per_level_i < per_r);
wire ber_hold = (ber_level_i > `TDC_RST_BER);

////////////////////////////////////////////////////////////////////////////////
// Outputs
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
   begin
      use_fft_o      <= `TDC_RST_FFT;
      use_guard_o    <= `TDC_RST_GUARD;
      use_mod_o      <= `TDC_RST_MOD;
      use_hp_o       <= `TDC_RST_RATE;
      use_lp_o       <= `TDC_RST_RATE;
      use_hier_o     <= `TDC_RST_HIER;
      chan_width_o   <= `TDC_RST_BW;
      carrier_span_o <= `TDC_DEF_SPAN;
      phase_fix_en_o <= 1'b1;
      osc_ppm_o      <= `TDC_RST_PPM;
      burst_sup_en_o <= 1'b0;
      qdet_dur_o     <= `TDC_RST_QDET;
      cg_acq_o       <= `TDC_RST_CGA;
      cg_fol_o       <= `TDC_RST_CGF;
      sg_acq_o       <= `TDC_RST_SGA;
      sg_fol_o       <= `TDC_RST_SGF;
      relock_o       <= 1'b0;
      boot_entry_o   <= 32'h0000_0000;
      patch_hdr_o    <= 32'h0000_0000;
      patch_tgt_o    <= 32'h0000_0000;
      core_reset_o   <= 1'b0;
   end
   else
   begin
      use_fft_o   <= auto_off_r ? fft_r   : dec_fft_i;
      use_guard_o <= auto_off_r ? guard_r : dec_guard_i;
      use_hp_o    <= auto_off_r ? hp_r    : dec_hp_i;
      use_lp_o    <= auto_off_r ? lp_r    : dec_lp_i;
      use_hier_o  <= auto_off_r ? hier_r  : dec_hier_i;
      use_mod_o   <= (cab_s2_r || auto_off_r) ? mod_r : dec_mod_i;
      chan_width_o   <= bw_r;
      // A zero span means the default, so the loop never sees a zero range
      carrier_span_o <= (span_r == 12'h000) ? `TDC_DEF_SPAN : span_r;
      phase_fix_en_o <= cpe_r;
      // Out-of-range accuracy is clipped rather than trusted
      osc_ppm_o      <= (ppm_r > `TDC_MAX_PPM) ? `TDC_MAX_PPM : ppm_r;
      burst_sup_en_o <= burst_r;
      qdet_dur_o     <= qdet_r;
      cg_acq_o       <= cga_r;
      cg_fol_o       <= cgf_r;
      sg_acq_o       <= sga_r;
      sg_fol_o       <= sgf_r;
      relock_o       <= tick_r && !cab_s2_r && per_bad && !ber_hold;
      boot_entry_o   <= jump_r;
      patch_hdr_o    <= hdr_r;
      patch_tgt_o    <= tgt_r;
      core_reset_o   <= ce_s2_r && rsten_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, registered one cycle after the read strobe
always @(posedge clk_sys_i or negedge arst_n_i)
begin
   if (!arst_n_i)
      reg_rdata_o <= 32'h0000_0000;
   else if (reg_rd_i)
   begin
      if (reg_addr_i == `TDC_A_AUTO)
         reg_rdata_o <= {31'h0, auto_off_r};
      else if (reg_addr_i == `TDC_A_FFT)
         reg_rdata_o <= {28'h0, fft_r};
      else if (reg_addr_i == `TDC_A_GUARD)
         reg_rdata_o <= {29'h0, guard_r};
      else if (reg_addr_i == `TDC_A_MOD)
         reg_rdata_o <= {26'h0, mod_r};
      else if (reg_addr_i == `TDC_A_HP)
         reg_rdata_o <= {28'h0, hp_r};
      else if (reg_addr_i == `TDC_A_LP)
         reg_rdata_o <= {28'h0, lp_r};
      else if (reg_addr_i == `TDC_A_HIER)
         reg_rdata_o <= {29'h0, hier_r};
      else if (reg_addr_i == `TDC_A_BW)
         reg_rdata_o <= {18'h0, bw_r};
      else if (reg_addr_i == `TDC_A_SPAN)
         reg_rdata_o <= {20'h0, span_r};
      else if (reg_addr_i == `TDC_A_CPE)
         reg_rdata_o <= {31'h0, cpe_r};
      else if (reg_addr_i == `TDC_A_PPM)
         reg_rdata_o <= {24'h0, ppm_r};
      else if (reg_addr_i == `TDC_A_BURST)
         reg_rdata_o <= {31'h0, burst_r};
      else if (reg_addr_i == `TDC_A_QDET)
         reg_rdata_o <= {28'h0, qdet_r};
      else if (reg_addr_i == `TDC_A_PER)
         reg_rdata_o <= {27'h0, per_r};
      // The hold level is fixed, so writes to it are dropped and reads give the constant
      else if (reg_addr_i == `TDC_A_BER)
         reg_rdata_o <= {27'h0, `TDC_RST_BER};
      else if (reg_addr_i == `TDC_A_CGA)
         reg_rdata_o <= {28'h0, cga_r};
      else if (reg_addr_i == `TDC_A_CGF)
         reg_rdata_o <= {28'h0, cgf_r};
      else if (reg_addr_i == `TDC_A_SGA)
         reg_rdata_o <= {28'h0, sga_r};
      else if (reg_addr_i == `TDC_A_SGF)
         reg_rdata_o <= {28'h0, sgf_r};
      else if (reg_addr_i == `TDC_A_BOOT)
         reg_rdata_o <= {29'h0, wderr_r, 1'b0, boot_s2_r};
      else if (reg_addr_i == `TDC_A_PATCHREV)
         reg_rdata_o <= {24'h0, prev_r};
      else if (reg_addr_i == `TDC_A_JUMP)
         reg_rdata_o <= jump_r;
      else if (reg_addr_i == `TDC_A_FAULT)
         reg_rdata_o <= {30'h0, !halted_r, rsten_r};
      else if (reg_addr_i == `TDC_A_HDR)
         reg_rdata_o <= hdr_r;
      else if (reg_addr_i == `TDC_A_TGT)
         reg_rdata_o <= tgt_r;
      else
         reg_rdata_o <= 32'h0000_0000;
   end
end

endmodule

// file: test/tdc_config_regs_assertions.sv
`timescale 1ns/10ps
`include "tdc_consts.vh"
module tdc_config_regs_assertions
#(
   parameter MEAS_CYCLES = `TDC_MEAS_CYC
)
(
   input wire        clk_sys_i,
   input wire        arst_n_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [11:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        cable_mode_i,
   input wire        core_err_i,
   input wire [31:0] reg_rdata_o,
   input wire [13:0] chan_width_o,
   input wire [11:0] carrier_span_o,
   input wire        phase_fix_en_o,
   input wire [7:0]  osc_ppm_o,
   input wire        burst_sup_en_o,
   input wire        relock_o,
   input wire [31:0] patch_hdr_o,
   input wire        core_reset_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_wr(a);
      reg_wr_i && reg_addr_i == a;
   endsequence
   a_width_wr:
   assert property (s_wr(`TDC_A_BW) |-> ##2 chan_width_o == $past(reg_wdata_i[13:0], 2))
      else $error("channel width write not applied");
   a_span_zero:
   assert property (s_wr(`TDC_A_SPAN) ##0 reg_wdata_i[11:0] == 12'h000
                    |-> ##2 carrier_span_o == 12'h032)
      else $error("zero span did not select default");
   a_phase_wr:
   assert property (s_wr(`TDC_A_CPE) |-> ##2 phase_fix_en_o == $past(reg_wdata_i[0], 2))
      else $error("phase fix enable not applied");
   a_burst_wr:
   assert property (s_wr(`TDC_A_BURST) |-> ##2 burst_sup_en_o == $past(reg_wdata_i[0], 2))
      else $error("burst suppress enable not applied");
   a_ppm_clip:
   assert property (s_wr(`TDC_A_PPM) |-> ##2 osc_ppm_o == (($past(reg_wdata_i[7:0], 2) > 8'hc8)
                    ? 8'hc8 : $past(reg_wdata_i[7:0], 2)))
      else $error("oscillator span wrong");
   a_hold_ro:
   assert property (reg_rd_i && reg_addr_i == `TDC_A_BER |=> reg_rdata_o == 32'h0000_0008)
      else $error("hold level not fixed");
   a_relock_cable:
   assert property (cable_mode_i [*5] |-> !relock_o)
      else $error("relock raised in cable mode");
   a_relock_pulse:
   assert property (relock_o |=> !relock_o)
      else $error("relock longer than one cycle");
   a_core_idle:
   assert property (!core_err_i [*5] |-> !core_reset_o)
      else $error("core reset without error");
   a_header_wr:
   assert property (s_wr(`TDC_A_HDR) |-> ##2 patch_hdr_o == $past(reg_wdata_i, 2))
      else $error("patch header write not applied");
endmodule

bind tdc_config_regs tdc_config_regs_assertions #(.MEAS_CYCLES(MEAS_CYCLES))
   tdc_config_regs_assertions_inst (.clk_sys_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .cable_mode_i, .core_err_i, .reg_rdata_o, .chan_width_o, .carrier_span_o,
   .phase_fix_en_o, .osc_ppm_o, .burst_sup_en_o, .relock_o, .patch_hdr_o, .core_reset_o);

// file: test/tdc_config_regs_tb.sv
`timescale 1ns/10ps
`include "tdc_consts.vh"
module tdc_config_regs_tb;
   reg         clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, cable_mode_i;
   reg         boot_done_i, wdog_err_i, core_err_i;
   reg  [11:0] reg_addr_i;
   reg  [31:0] reg_wdata_i;
   reg  [3:0]  dec_fft_i, dec_hp_i, dec_lp_i;
   reg  [2:0]  dec_guard_i, dec_hier_i;
   reg  [5:0]  dec_mod_i;
   reg  [4:0]  per_level_i, ber_level_i;
   wire [31:0] reg_rdata_o, boot_entry_o, patch_hdr_o, patch_tgt_o;
   wire [3:0]  use_fft_o, use_hp_o, use_lp_o, qdet_dur_o, cg_acq_o, cg_fol_o, sg_acq_o, sg_fol_o;
   wire [2:0]  use_guard_o, use_hier_o;
   wire [5:0]  use_mod_o;
   wire [13:0] chan_width_o;
   wire [11:0] carrier_span_o;
   wire [7:0]  osc_ppm_o;
   wire        phase_fix_en_o, burst_sup_en_o, relock_o, core_reset_o;
   integer     failures, comparisons, cycles, i, n;
   localparam [47:0] mod_codes  = 48'h0307_0809_0a0b;
   localparam [19:0] rate_codes = 20'h1_2357;
   localparam [15:0] hier_codes = 16'h1235;
   // Short measurement period keeps the relock scenario within a few hundred cycles
   tdc_config_regs #(.MEAS_CYCLES(16)) tdc_config_regs_inst (.clk_sys_i, .arst_n_i, .reg_wr_i,
      .reg_rd_i, .reg_addr_i, .reg_wdata_i, .cable_mode_i, .dec_fft_i, .dec_guard_i, .dec_mod_i,
      .dec_hp_i, .dec_lp_i, .dec_hier_i, .per_level_i, .ber_level_i, .boot_done_i, .wdog_err_i,
      .core_err_i, .reg_rdata_o, .use_fft_o, .use_guard_o, .use_mod_o, .use_hp_o, .use_lp_o,
      .use_hier_o, .chan_width_o, .carrier_span_o, .phase_fix_en_o, .osc_ppm_o, .burst_sup_en_o,
      .qdet_dur_o, .cg_acq_o, .cg_fol_o, .sg_acq_o, .sg_fol_o, .relock_o, .boot_entry_o,
      .patch_hdr_o, .patch_tgt_o, .core_reset_o);
   ////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] g, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Every write waits out the two-cycle effect so callers may check outputs at once
   task wr(input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_sys_i);
         reg_wr_i    <= 1'b1;
         reg_addr_i  <= a;
         reg_wdata_i <= d;
         @(posedge clk_sys_i);
         reg_wr_i <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task rd(input [11:0] a, input [31:0] e);
      begin
         @(posedge clk_sys_i);
         reg_rd_i   <= 1'b1;
         reg_addr_i <= a;
         @(posedge clk_sys_i);
         reg_rd_i <= 1'b0;
         @(posedge clk_sys_i);
         #1;
         chk(reg_rdata_o, e);
      end
   endtask
   task wait_cy(input integer c);
      begin
         repeat (c) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task count_relock;
      begin
         n = 0;
         // Exactly two measurement ticks fall in any 32 consecutive cycles
         for (i = 0; i < 32; i = i + 1)
         begin
            wait_cy(1);
            if (relock_o === 1'b1)
               n = n + 1;
         end
      end
   endtask
   task test_done;
      begin
         $display("comparisons=%0d failures=%0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         rd(`TDC_A_AUTO, 32'h0);
         chk({28'h0, use_fft_o}, 32'hc);
         rd(`TDC_A_FFT, 32'hd);
         rd(`TDC_A_GUARD, 32'h1);
         rd(`TDC_A_MOD, 32'h3);
         rd(`TDC_A_LP, 32'h1);
         rd(`TDC_A_HIER, 32'h1);
         rd(`TDC_A_BW, 32'h320);
         chk({20'h0, carrier_span_o}, 32'h32);
         rd(`TDC_A_CPE, 32'h1);
         rd(`TDC_A_PPM, 32'h64);
         rd(`TDC_A_BURST, 32'h0);
         rd(`TDC_A_QDET, 32'h2);
         rd(`TDC_A_PER, 32'h6);
         rd(`TDC_A_SGF, 32'h6);
         rd(`TDC_A_CGA, 32'hd);
         rd(`TDC_A_BOOT, 32'h0);
         rd(`TDC_A_FAULT, 32'h3);
         rd(`TDC_A_TGT, 32'h0);
         rd(`TDC_A_JUMP, 32'h0);
         $display("test reset done");
      end
   endtask
   task t_forced;
      begin
         wr(`TDC_A_AUTO, 32'h1);
         for (i = 0; i < 6; i = i + 1)
         begin
            wr(`TDC_A_MOD, {24'h0, mod_codes[40 - 8 * i +: 8]});
            chk({26'h0, use_mod_o}, {24'h0, mod_codes[40 - 8 * i +: 8]});
         end
         for (i = 0; i < 5; i = i + 1)
         begin
            wr(`TDC_A_HP, {28'h0, rate_codes[16 - 4 * i +: 4]});
            wr(`TDC_A_LP, {28'h0, rate_codes[4 * i +: 4]});
            chk({24'h0, use_hp_o, use_lp_o},
                {24'h0, rate_codes[16 - 4 * i +: 4], rate_codes[4 * i +: 4]});
         end
         for (i = 0; i < 4; i = i + 1)
         begin
            wr(`TDC_A_GUARD, i + 1);
            wr(`TDC_A_HIER, {29'h0, hier_codes[12 - 4 * i +: 3]});
            chk({26'h0, use_guard_o, use_hier_o},
                {26'h0, i[2:0] + 3'h1, hier_codes[12 - 4 * i +: 3]});
            wr(`TDC_A_FFT, 32'hb + i % 3);
            chk({28'h0, use_fft_o}, 32'hb + i % 3);
         end
         wr(`TDC_A_AUTO, 32'h0);
         chk({8'h0, use_fft_o, use_mod_o, use_guard_o, use_hp_o, use_lp_o, use_hier_o},
             {8'h0, 4'hc, 6'h09, 3'h2, 4'h3, 4'h7, 3'h3});
         @(posedge clk_sys_i);
         cable_mode_i <= 1'b1;
         wait_cy(6);
         chk({26'h0, use_mod_o}, 32'hb);
         @(posedge clk_sys_i);
         cable_mode_i <= 1'b0;
         $display("test forced done");
      end
   endtask
   task t_fields;
      begin
         wr(`TDC_A_BW, 32'h3fff);
         chk({18'h0, chan_width_o}, 32'h3fff);
         wr(`TDC_A_SPAN, 32'hc8);
         chk({20'h0, carrier_span_o}, 32'hc8);
         wr(`TDC_A_SPAN, 32'h0);
         chk({20'h0, carrier_span_o}, 32'h32);
         wr(`TDC_A_PPM, 32'hc9);
         chk({24'h0, osc_ppm_o}, 32'hc8);
         wr(`TDC_A_CPE, 32'h0);
         wr(`TDC_A_BURST, 32'h1);
         chk({phase_fix_en_o, burst_sup_en_o}, 2'b01);
         wr(`TDC_A_QDET, 32'hf);
         wr(`TDC_A_CGF, 32'h3);
         wr(`TDC_A_SGA, 32'h5);
         chk({qdet_dur_o, cg_fol_o, sg_acq_o}, 12'hf35);
         wr(`TDC_A_CGA, 32'h7);
         wr(`TDC_A_SGF, 32'h2);
         chk({24'h0, cg_acq_o, sg_fol_o}, 32'h72);
         wr(`TDC_A_JUMP, 32'hdead_beef);
         wr(`TDC_A_HDR, 32'h8001_0040);
         wr(`TDC_A_TGT, 32'hffff_fffc);
         chk(boot_entry_o, 32'hdead_beef);
         chk(patch_hdr_o ^ patch_tgt_o, 32'h7ffe_ffbc);
         wr(`TDC_A_BER, 32'h1f);
         rd(`TDC_A_BER, 32'h8);
         rd(12'h3fc, 32'h0);
         $display("test fields done");
      end
   endtask
   task t_status;
      begin
         @(posedge clk_sys_i);
         boot_done_i <= 1'b1;
         wdog_err_i  <= 1'b1;
         wait_cy(4);
         @(posedge clk_sys_i);
         wdog_err_i <= 1'b0;
         wait_cy(4);
         rd(`TDC_A_BOOT, 32'h5);
         wr(`TDC_A_BOOT, 32'h2);
         rd(`TDC_A_BOOT, 32'h1);
         @(posedge clk_sys_i);
         core_err_i <= 1'b1;
         wait_cy(5);
         chk({31'h0, core_reset_o}, 32'h1);
         wr(`TDC_A_FAULT, 32'h0);
         chk({31'h0, core_reset_o}, 32'h0);
         rd(`TDC_A_FAULT, 32'h0);
         @(posedge clk_sys_i);
         core_err_i <= 1'b0;
         wr(`TDC_A_FAULT, 32'h1);
         $display("test status done");
      end
   endtask
   task t_relock;
      begin
         @(posedge clk_sys_i);
         per_level_i <= 5'd3;
         count_relock;
         chk(n, 2);
         @(posedge clk_sys_i);
         ber_level_i <= 5'd12;
         wait_cy(4);
         count_relock;
         chk(n, 0);
         @(posedge clk_sys_i);
         ber_level_i <= 5'd5;
         wr(`TDC_A_PER, 32'h0);
         count_relock;
         chk(n, 0);
         $display("test relock done");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         test_done;
      end
   end
   initial
   begin
      failures = 0; comparisons = 0; cycles = 0;
      arst_n_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 12'h0;
      reg_wdata_i = 32'h0; cable_mode_i = 1'b0; boot_done_i = 1'b0; wdog_err_i = 1'b0;
      core_err_i = 1'b0; dec_fft_i = 4'hc; dec_guard_i = 3'h2; dec_mod_i = 6'h09;
      dec_hp_i = 4'h3; dec_lp_i = 4'h7; dec_hier_i = 3'h3; per_level_i = 5'h1f;
      ber_level_i = 5'd5;
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_reset;
      t_forced;
      t_fields;
      t_status;
      t_relock;
      test_done;
   end
endmodule
